/* File: hpsd_pkg.sv */
// package: register map, field layout and reset values of the port status block
package hpsd_pkg;
    localparam logic [11:0] PORT_ONE_STATUS_CONTROL_OFF    = 12'h064;
    localparam logic [11:0] ISO_DESCRIPTOR_DONE_BITMAP_OFF = 12'h130;
    localparam logic [11:0] CFG_OFF                        = 12'h200;
    localparam logic [11:0] IRQ_STATUS_OFF                 = 12'h204;
    localparam logic [11:0] IRQ_MASK_OFF                   = 12'h208;

    localparam int TEST_SELECT_LSB     = 16;
    localparam int INDICATOR_CTRL_LSB  = 14;
    localparam int HANDOFF_OWNER_BIT   = 13;
    localparam int VBUS_POWER_ON_BIT   = 12;
    localparam int LINE_PLUS_BIT       = 11;
    localparam int LINE_MINUS_BIT      = 10;
    localparam int BUS_RESET_BIT       = 8;
    localparam int PORT_ASLEEP_BIT     = 7;
    localparam int RESUME_FORCE_BIT    = 6;
    localparam int LINK_ENABLED_BIT    = 2;
    localparam int ATTACH_CHANGE_BIT   = 1;
    localparam int ATTACHED_BIT        = 0;

    // configuration register bits
    localparam int CFG_ROUTING_BIT     = 0;
    localparam int CFG_INDICATOR_BIT   = 1;
    localparam int CFG_PWR_SWITCH_BIT  = 2;

    // interrupt status bits
    localparam int IRQ_ATTACH_BIT      = 0;
    localparam int IRQ_DONE_BIT        = 1;

    localparam logic [3:0]  TEST_SELECT_RST  = 4'h0;
    localparam logic [1:0]  INDICATOR_RST    = 2'h0;
    localparam logic        HANDOFF_RST      = 1'b1;
    localparam logic [31:0] DONE_MAP_RST     = 32'h00000000;
    localparam logic [2:0]  CFG_RST          = 3'h0;
    localparam logic [1:0]  IRQ_RST          = 2'h0;
endpackage

/* File: hpsd_regs.sv */
// register bank: port one status/control, iso done bitmap, config and interrupts
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module hpsd_regs
    import hpsd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        plus_line,
    input  wire logic        minus_line,
    input  wire logic        port_in_reset,
    input  wire logic        port_suspended,
    input  wire logic        port_resume,
    input  wire logic        port_enabled,
    input  wire logic        device_present,
    input  wire logic [31:0] descriptor_done,
    output logic      [3:0]  test_select,
    output logic      [1:0]  indicator_ctrl,
    output logic             handoff_owner,
    output logic             vbus_power_on,
    output logic             irq
);
    import hpsd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage one is read only by stage two
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    wire  [5:0] pins_raw = {plus_line, minus_line, port_in_reset,
                            port_suspended, port_resume, port_enabled};
    logic       present_s1_reg;
    logic       present_s2_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg      <= 6'h00;
            sync2_reg      <= 6'h00;
            present_s1_reg <= 1'b0;
            present_s2_reg <= 1'b0;
        end else begin
            sync1_reg      <= pins_raw;
            sync2_reg      <= sync1_reg;
            present_s1_reg <= device_present;
            present_s2_reg <= present_s1_reg;
        end
    end

    wire s_plus    = sync2_reg[5];
    wire s_minus   = sync2_reg[4];
    wire s_reset   = sync2_reg[3];
    wire s_suspend = sync2_reg[2];
    wire s_resume  = sync2_reg[1];
    wire s_enabled = sync2_reg[0];

    ////////////////////////////////////////////////////////////////////////
    // apb decode; one wait-free access phase
    wire        access   = psel & penable;
    wire        wr_en    = access & pwrite;
    wire        rd_en    = access & ~pwrite;
    wire        hit_port = (paddr == PORT_ONE_STATUS_CONTROL_OFF);
    wire        hit_done = (paddr == ISO_DESCRIPTOR_DONE_BITMAP_OFF);
    wire        hit_cfg  = (paddr == CFG_OFF);
    wire        hit_ists = (paddr == IRQ_STATUS_OFF);
    wire        hit_imsk = (paddr == IRQ_MASK_OFF);
    wire        mapped   = hit_port | hit_done | hit_cfg | hit_ists | hit_imsk;
    wire        wr_port  = wr_en & hit_port;
    wire        wr_cfg   = wr_en & hit_cfg;

    ////////////////////////////////////////////////////////////////////////
    // configuration: routing, indicator and power switch capability
    logic [2:0] cfg_reg;
    logic       routing_prev_reg;
    wire  [2:0] cfg_next = wr_cfg ? pwdata[2:0] : cfg_reg;
    wire        routing_configured   = cfg_reg[CFG_ROUTING_BIT];
    wire        indicator_capable    = cfg_reg[CFG_INDICATOR_BIT];
    wire        power_switch_capable = cfg_reg[CFG_PWR_SWITCH_BIT];
    wire        routing_rise         = routing_configured & ~routing_prev_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg          <= CFG_RST;
            routing_prev_reg <= 1'b0;
        end else begin
            cfg_reg          <= cfg_next;
            routing_prev_reg <= routing_configured;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port control fields
    logic [3:0] test_sel_reg;
    logic [1:0] ind_reg;
    logic       owner_reg;
    logic       power_reg;

    wire [3:0] test_sel_next = wr_port ? pwdata[TEST_SELECT_LSB +: 4] : test_sel_reg;
    wire [1:0] ind_next = (wr_port & indicator_capable) ?
                          pwdata[INDICATOR_CTRL_LSB +: 2] : ind_reg;
    // fixed power when switching is absent: port is powered from the first clock after reset (reset loads zero)
    wire       power_next = !power_switch_capable ? 1'b1 :
                            (wr_port ? pwdata[VBUS_POWER_ON_BIT] : power_reg);
    // configured low forces one; rising edge clears; otherwise software owns it
    wire       owner_next = !routing_configured ? 1'b1 :
                            routing_rise ? 1'b0 :
                            (wr_port ? pwdata[HANDOFF_OWNER_BIT] : owner_reg);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_sel_reg <= TEST_SELECT_RST;
            ind_reg      <= INDICATOR_RST;
            owner_reg    <= HANDOFF_RST;
            power_reg    <= 1'b0;
        end else begin
            test_sel_reg <= test_sel_next;
            ind_reg      <= ind_next;
            owner_reg    <= owner_next;
            power_reg    <= power_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // connect status and change flag
    logic attached_reg;
    logic change_reg;
    wire  attach_edge = present_s2_reg ^ attached_reg;
    // a new edge wins over a simultaneous write-one clear
    wire  change_next = attach_edge ? 1'b1 :
                        ((wr_port & pwdata[ATTACH_CHANGE_BIT]) ? 1'b0 : change_reg);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            attached_reg <= 1'b0;
            change_reg   <= 1'b0;
        end else begin
            attached_reg <= present_s2_reg;
            change_reg   <= change_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // iso done bitmap: completion sets, read clears, set wins
    logic [31:0] done_reg;
    wire         rd_done   = rd_en & hit_done;
    wire  [31:0] done_next = descriptor_done |
                             (rd_done ? 32'h00000000 : done_reg);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_reg <= DONE_MAP_RST;
        end else begin
            done_reg <= done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: attach change and descriptor completion, write one clears
    logic [1:0] ists_reg;
    logic [1:0] imsk_reg;
    logic       irq_reg;
    wire  [1:0] irq_events = {|descriptor_done, attach_edge};
    wire  [1:0] ists_clr   = (wr_en & hit_ists) ? pwdata[1:0] : 2'h0;
    wire  [1:0] ists_next  = irq_events | (ists_reg & ~ists_clr);
    wire  [1:0] imsk_next  = (wr_en & hit_imsk) ? pwdata[1:0] : imsk_reg;
    wire        irq_next   = |(ists_next & imsk_next);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ists_reg <= IRQ_RST;
            imsk_reg <= IRQ_RST;
            irq_reg  <= 1'b0;
        end else begin
            ists_reg <= ists_next;
            imsk_reg <= imsk_next;
            irq_reg  <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data assembly; reserved bits read zero whatever software
    // writes to them, since the word is built up from zero
    function automatic logic [31:0] port_word(
        input logic [3:0] tsel,
        input logic [1:0] ind,
        input logic       own,
        input logic       pwr
    );
        logic [31:0] w;
        w = 32'h00000000;
        w[TEST_SELECT_LSB +: 4]    = tsel;
        w[INDICATOR_CTRL_LSB +: 2] = pwr ? ind : 2'h0;
        w[HANDOFF_OWNER_BIT]       = own;
        w[VBUS_POWER_ON_BIT]       = pwr;
        w[LINE_PLUS_BIT]           = s_plus;
        w[LINE_MINUS_BIT]          = s_minus;
        w[BUS_RESET_BIT]           = pwr & s_reset;
        w[PORT_ASLEEP_BIT]         = pwr & s_suspend;
        w[RESUME_FORCE_BIT]        = pwr & s_resume;
        w[LINK_ENABLED_BIT]        = pwr & s_enabled;
        w[ATTACH_CHANGE_BIT]       = pwr & change_reg;
        w[ATTACHED_BIT]            = pwr & attached_reg;
        return w;
    endfunction

    wire [31:0] rd_mux =
        hit_port ? port_word(test_sel_reg, ind_reg, owner_reg, power_reg) :
        hit_done ? done_next :
        hit_cfg  ? {29'h0, cfg_reg} :
        hit_ists ? {30'h0, ists_reg} :
        hit_imsk ? {30'h0, imsk_reg} : 32'h00000000;

    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    // answer registered one cycle after setup so outputs leave flip-flops;
    // done map word includes completions landing at the setup edge, else the
    // access-edge clear would drop them unseen
    wire         setup = psel & ~penable;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg  <= 32'h00000000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= setup ? rd_mux : prdata_reg;
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
        end
    end

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign test_select    = test_sel_reg;
    assign indicator_ctrl = ind_reg;
    assign handoff_owner  = owner_reg;
    assign vbus_power_on  = power_reg;
    assign irq            = irq_reg;
endmodule

/* File: hpsd_usb_dev.sv */
// model of the usb device attached to the downstream port pins
`timescale 1ns/1ps
module hpsd_usb_dev (
    input  wire logic       attach,
    input  wire logic [3:0] state,
    output logic            plus_line,
    output logic            minus_line,
    output logic            device_present,
    output logic            port_in_reset,
    output logic            port_suspended,
    output logic            port_resume,
    output logic            port_enabled
);
    // detached: host pull-downs hold both lines low; attached idle is j, resume is k
    assign device_present = attach;
    assign plus_line      = attach & ~state[1];
    assign minus_line     = attach & state[1];
    assign {port_in_reset, port_suspended, port_resume, port_enabled} = attach ? state : 4'h0;
endmodule

/* File: hpsd_regs_monitor.sv */
// assertion checker for the port status register block
`timescale 1ns/1ps
module hpsd_regs_chk
    import hpsd_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  test_select,
    input wire logic        handoff_owner,
    input wire logic        vbus_power_on
);
    wire logic acc    = psel & penable & pready;
    wire logic mapped = paddr inside {PORT_ONE_STATUS_CONTROL_OFF, ISO_DESCRIPTOR_DONE_BITMAP_OFF,
                                      CFG_OFF, IRQ_STATUS_OFF, IRQ_MASK_OFF};
    wire logic wr_prt = acc & pwrite & (paddr == PORT_ONE_STATUS_CONTROL_OFF);
    wire logic wr_cfg = acc & pwrite & (paddr == CFG_OFF);
    wire logic wr_ctl = wr_prt | wr_cfg;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_ready_next: assert property (psel && !penable |=> pready) else $error("no pready");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    a_ok_mapped: assert property (acc && mapped |-> !pslverr) else $error("mapped refused");
    a_tsel_value: assert property (wr_prt |=> test_select == $past(pwdata[19:16]))
        else $error("test_select not written");
    a_owner_route: assert property (wr_cfg && !pwdata[0] |-> ##[1:2] handoff_owner)
        else $error("owner not forced");
    a_owner_cause: assert property ($changed(handoff_owner) |-> $past(wr_ctl) || $past(wr_ctl, 2))
        else $error("owner moved alone");
    a_power_forced: assert property (wr_cfg && !pwdata[2] |-> ##[1:2] vbus_power_on)
        else $error("power not forced");
    a_power_cause: assert property ($changed(vbus_power_on) |->
        !$past(nrst, 2) || $past(wr_ctl) || $past(wr_ctl, 2)) else $error("power moved alone");
    c_unmapped: cover property (acc && !mapped);
    c_route_on: cover property (wr_cfg && pwdata[0]);
    c_power_off: cover property ($fell(vbus_power_on));
endmodule
bind hpsd_regs hpsd_regs_chk i_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .test_select(test_select), .handoff_owner(handoff_owner),
    .vbus_power_on(vbus_power_on));

/* File: tb_hpsd_regs.sv */
// self-checking bench for the port status register block
`timescale 1ns/1ps
module tb_hpsd_regs;
    import hpsd_pkg::*;
    logic        clk, nrst, psel, penable, pwrite, attach, pready, pslverr, irq;
    logic        plus_line, minus_line, port_in_reset, port_suspended, port_resume;
    logic        port_enabled, device_present, handoff_owner, vbus_power_on;
    logic        own, pwr, att, chg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, done, d;
    logic [3:0]  test_select, st, tsel;
    logic [1:0]  indicator_ctrl, ind;
    logic [33:0] q;
    logic [33:0] exp_q[$];
    int          fail_count, num_checks, cyc;
    hpsd_regs i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .plus_line(plus_line), .minus_line(minus_line), .port_in_reset(port_in_reset),
        .port_suspended(port_suspended), .port_resume(port_resume), .port_enabled(port_enabled),
        .device_present(device_present), .descriptor_done(done), .test_select(test_select),
        .indicator_ctrl(indicator_ctrl), .handoff_owner(handoff_owner),
        .vbus_power_on(vbus_power_on), .irq(irq));
    hpsd_usb_dev i_dev (.attach(attach), .state(st), .plus_line(plus_line),
        .minus_line(minus_line), .device_present(device_present), .port_in_reset(port_in_reset),
        .port_suspended(port_suspended), .port_resume(port_resume), .port_enabled(port_enabled));
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
                       input logic [32:0] e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        exp_q.push_back({w, e});
        @(posedge clk);
        penable <= 1'b1;
        // look at pready where it is settled, then release at the sampling edge
        @(negedge clk);
        while (pready !== 1'b1) @(negedge clk);
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 33'h0);
    endtask
    function automatic logic [31:0] pexp();
        logic [31:0] r;
        r = {12'h0, tsel, 2'h0, own, pwr, att & ~st[1], att & st[1], 10'h0};
        if (pwr) r = r | {16'h0, ind, 5'h0, st[3:1], 3'h0, st[0], chg, att};
        return r;
    endfunction
    function automatic logic [31:0] pwv(input logic [1:0] i, input logic c);
        return {12'h0, tsel, i, 1'b0, pwr, 10'h0, c, 1'b0};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // answers stand one whole cycle; checked mid-cycle, away from the launching edge
    always @(negedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            fail_count++;
            end_sim();
        end
        if (pready === 1'b1) begin
            q = exp_q.pop_front();
            if (q[33]) cmp({32'h0, pslverr}, {32'h0, q[32]});
            else cmp({pslverr, prdata}, q[32:0]);
        end
    end
    initial begin
        {nrst, psel, penable, pwrite, attach, paddr, pwdata, done, st} = '0;
        {fail_count, num_checks, cyc} = '0;
        {tsel, ind, att, chg} = '0;
        {own, pwr} = 2'h3;
        d = $urandom(5947);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(CFG_OFF, 32'h0);
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
        $display("reset and map test done");
        tsel = 4'($urandom_range(15, 1));
        wr(PORT_ONE_STATUS_CONTROL_OFF, pwv(2'h3, 1'b0));
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        cmp({29'h0, test_select}, {29'h0, tsel});
        wr(CFG_OFF, 32'h2);
        ind = 2'h2;
        wr(PORT_ONE_STATUS_CONTROL_OFF, pwv(ind, 1'b0));
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        cmp({31'h0, indicator_ctrl}, {31'h0, ind});
        wr(CFG_OFF, 32'h3);
        own = 1'b0;
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        wr(CFG_OFF, 32'h2);
        own = 1'b1;
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        $display("control field test done");
        attach <= 1'b1;
        {att, chg} = 2'h3;
        repeat (5) @(posedge clk);
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        wr(PORT_ONE_STATUS_CONTROL_OFF, pwv(ind, 1'b0));
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        wr(PORT_ONE_STATUS_CONTROL_OFF, pwv(ind, 1'b1));
        chg = 1'b0;
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        rd(IRQ_STATUS_OFF, 32'h1);
        wr(IRQ_MASK_OFF, 32'h3);
        repeat (2) @(posedge clk);
        cmp({32'h0, irq}, 33'h1);
        wr(IRQ_STATUS_OFF, 32'h1);
        repeat (2) @(posedge clk);
        cmp({32'h0, irq}, 33'h0);
        for (int i = 0; i < 5; i++) begin
            st <= (i == 4) ? 4'h7 : 4'(1 << i);
            repeat (5) @(posedge clk);
            rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        end
        $display("attach and state test done");
        wr(CFG_OFF, 32'h6);
        pwr = 1'b0;
        wr(PORT_ONE_STATUS_CONTROL_OFF, pwv(ind, 1'b0));
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        cmp({32'h0, vbus_power_on}, 33'h0);
        pwr = 1'b1;
        wr(PORT_ONE_STATUS_CONTROL_OFF, pwv(ind, 1'b0));
        rd(PORT_ONE_STATUS_CONTROL_OFF, pexp());
        $display("power test done");
        d = $urandom();
        @(posedge clk);
        done <= d;
        @(posedge clk);
        done <= 32'h0;
        rd(ISO_DESCRIPTOR_DONE_BITMAP_OFF, d);
        rd(ISO_DESCRIPTOR_DONE_BITMAP_OFF, 32'h0);
        rd(IRQ_STATUS_OFF, (d != 0) ? 32'h2 : 32'h0);
        $display("done map test done");
        repeat (2) @(posedge clk);
        end_sim();
    end
endmodule
